// ---- rtl/nvs_pkg.sv ----
// Constants and types shared by the two-wire memory target.
// Assumes a core clock of 40 MHz and a serial clock from the controller.
package nvs_pkg;

    // Memory geometry
    localparam int          MEM_WORDS      = 8192;
    localparam int          ADDR_W         = 13;
    localparam int          HI_ADDR_W      = ADDR_W - 8;
    localparam int          BYTE_W         = 8;
    localparam logic [12:0] ADDR_RST       = 13'h0000;
    localparam logic [12:0] ADDR_STEP      = 13'h0001;

    // Slot counter inside one nine-slot unit
    localparam logic [3:0]  SLOT_FIRST     = 4'h0;
    localparam logic [3:0]  SLOT_LAST_DATA = 4'h7;
    localparam logic [3:0]  SLOT_ACK       = 4'h8;
    localparam logic [3:0]  SLOT_STEP      = 4'h1;

    // Target address byte fields
    localparam int          TYPE_MSB       = 7;
    localparam int          TYPE_LSB       = 4;
    localparam int          SEL_MSB        = 3;
    localparam int          SEL_LSB        = 1;
    localparam int          DIR_BIT        = 0;
    localparam int          HS_MSB         = 7;
    localparam int          HS_LSB         = 3;
    localparam logic [4:0]  HS_MASTER_CODE = 5'h01;

    // Frame reset stays up this many core cycles after a start
    localparam logic [1:0]  START_HOLD     = 2'h2;
    localparam logic [1:0]  HOLD_ZERO      = 2'h0;
    localparam logic [1:0]  HOLD_STEP      = 2'h1;

    // Pin synchroniser reset values
    localparam logic [1:0]  BUS_PINS_RST   = 2'h3;
    localparam logic [3:0]  STRAP_PINS_RST = 4'h0;
    localparam logic        TOG_RST        = 1'b0;

    // Protocol states, Gray along address, word address, data
    typedef enum logic [2:0] {
        ST_ADDR   = 3'h0,
        ST_WHI    = 3'h1,
        ST_WLO    = 3'h3,
        ST_WDATA  = 3'h2,
        ST_READ   = 3'h6,
        ST_IGNORE = 3'h7
    } nvs_state_type;

endpackage

// ---- rtl/nvs_sync.sv ----
// Two-flop level synchroniser, one flop pair per bit.
// Assumes the input is a level that stays put for at least two edges.
`timescale 1ns/10ps
module nvs_sync #(
    parameter int         WIDTH   = 1,
    parameter logic [3:0] RST_VAL = 4'h0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL[WIDTH-1:0];
            sync_q <= RST_VAL[WIDTH-1:0];
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

// ---- rtl/nvs_i2c_mem.sv ----
// Two-wire target of an 8192 x 8 nonvolatile memory, storage included.
// Assumes an open-drain wire outside: the bench resolves sda from the
// enable, and the serial clock comes from the controller only.
// Contract
// - Start is sda falling with scl high; nothing runs before one.
// - Stop is sda rising with scl high; it ends the command.
// - Every unit is eight bits followed by one acknowledge slot.
// - Sample data on rising scl, change driven data after falling scl.
// - Sender releases after eight bits; receiver pulls low in slot nine.
// - Data line is only pulled low or released, never driven high.
// - Top four address bits must equal the device type, else ignore.
// - Next three bits must match the select pins; open pins read low.
// - Last address bit gives direction: zero write, one read.
// - A matching target address byte is acknowledged low.
// - Each word address and data byte of a write is acknowledged.
// - Read sends eight bits, then continues if controller acknowledges.
// - No acknowledge on read: release, await stop, go idle.
// - Write guard high blocks all stores; low or open allows them.
// - Byte write: start, address, two word bytes, one data, stop.
// - Further data bytes go to consecutive addresses.
// - Address past the last location wraps to zero.
// - Beyond 8192 bytes a write overwrites its own first bytes.
// - Current read gives n+1 after read at n, n after write at n.
// - Random read: write address phase, repeated start, then read.
// - Master code before commands selects high speed until stop.
`timescale 1ns/10ps
module nvs_i2c_mem
    import nvs_pkg::*;
#(
    // Arbitrary neutral value, set to the real device-type code
    parameter logic [3:0] DEV_TYPE_CODE = 4'h5
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       link_scl_i,
    input  wire logic       sda_i,
    input  wire logic [2:0] device_select_pins_i,
    input  wire logic       write_guard_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    output logic            hs_mode_o,
    output logic            bus_idle_o,
    output logic            write_blocked_o
);

    // ---- Core domain: start and stop watch ----
    logic       scl_s;
    logic       sda_s;
    logic       scl_prev_q;
    logic       sda_prev_q;
    logic       idle_q;
    logic       idle_d;
    logic [1:0] hold_q;
    logic [1:0] hold_d;
    logic       frame_rst_q;
    logic       frame_rst_d;
    logic       link_rst_q;
    logic       start_det;
    logic       stop_det;
    logic       blk_tog_s;
    logic       blk_tog_prev_q;
    logic       blocked_q;

    // ---- Link domain ----
    nvs_state_type          state_q;
    nvs_state_type          state_d;
    logic [3:0]             cnt_q;
    logic [3:0]             cnt_d;
    logic [BYTE_W-1:0]      rx_q;
    logic [BYTE_W-1:0]      rx_d;
    logic [BYTE_W-1:0]      tx_q;
    logic [BYTE_W-1:0]      tx_d;
    logic                   ack_q;
    logic                   ack_d;
    logic [HI_ADDR_W-1:0]   hi_q;
    logic [HI_ADDR_W-1:0]   hi_d;
    logic [ADDR_W-1:0]      addr_q;
    logic [ADDR_W-1:0]      addr_d;
    logic [ADDR_W-1:0]      ptr_q;
    logic [ADDR_W-1:0]      ptr_d;
    logic                   hs_q;
    logic                   hs_d;
    logic                   blk_tog_q;
    logic                   oe_n_q;
    logic                   oe_n_d;
    logic                   drv_lvl_q;
    logic [BYTE_W-1:0]      mem_q [MEM_WORDS];
    logic [2:0]             sel_s;
    logic                   guard_s;
    logic [BYTE_W-1:0]      byte_in;
    logic                   last_bit;
    logic                   ack_slot;
    logic                   type_hit;
    logic                   sel_hit;
    logic                   is_read;
    logic                   hs_hit;
    logic                   rd_next;
    logic                   master_ack;
    logic                   mem_we;
    logic                   blk_ev;
    logic [ADDR_W-1:0]      addr_inc;
    logic [ADDR_W-1:0]      ptr_inc;
    logic [ADDR_W-1:0]      word_addr;
    logic [BYTE_W-1:0]      rd_byte;
    logic [BYTE_W-1:0]      rd_next_byte;
    logic                   drive_ack;
    logic                   drive_data;

    // Bus pins reach the core clock through two flops each
    nvs_sync #(
        .WIDTH   (2),
        .RST_VAL ({2'h0, BUS_PINS_RST})
    ) u_bus_sync (
        .clk_i   (core_clk_i),
        .rst_i   (rst_i),
        .async_i ({link_scl_i, sda_i}),
        .sync_o  ({scl_s, sda_s})
    );

    // Write-blocked event toggle comes over from the link side
    nvs_sync #(
        .WIDTH   (1),
        .RST_VAL ({3'h0, TOG_RST})
    ) u_blk_sync (
        .clk_i   (core_clk_i),
        .rst_i   (rst_i),
        .async_i (blk_tog_q),
        .sync_o  (blk_tog_s)
    );

    // Edges of sda while scl stays high
    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // Idle from stop until the next start; repeated start keeps it low
    assign idle_d = stop_det | (idle_q & ~start_det);
    assign hold_d = start_det ? START_HOLD :
                    (hold_q != HOLD_ZERO) ? hold_q - HOLD_STEP : HOLD_ZERO;
    // Frame logic held cleared while idle and just after any start
    assign frame_rst_d = idle_d | (hold_d != HOLD_ZERO);

    // Core registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            scl_prev_q  <= 1'b1;
            sda_prev_q  <= 1'b1;
            idle_q      <= 1'b1;
            hold_q      <= HOLD_ZERO;
            frame_rst_q <= 1'b1;
            link_rst_q  <= 1'b1;
        end else begin
            scl_prev_q  <= scl_s;
            sda_prev_q  <= sda_s;
            idle_q      <= idle_d;
            hold_q      <= hold_d;
            frame_rst_q <= frame_rst_d;
            link_rst_q  <= 1'b0;
        end
    end

    // One core-cycle pulse per blocked store
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            blk_tog_prev_q <= TOG_RST;
            blocked_q      <= 1'b0;
        end else begin
            blk_tog_prev_q <= blk_tog_s;
            blocked_q      <= blk_tog_s ^ blk_tog_prev_q;
        end
    end

    assign bus_idle_o      = idle_q;
    assign write_blocked_o = blocked_q;

    // ---- Link domain, clocked by the controller's serial clock ----

    // Straps and guard pass two scl flops; guard is steady per frame
    nvs_sync #(
        .WIDTH   (4),
        .RST_VAL (STRAP_PINS_RST)
    ) u_strap_sync (
        .clk_i   (link_scl_i),
        .rst_i   (1'b0),
        .async_i ({write_guard_i, device_select_pins_i}),
        .sync_o  ({guard_s, sel_s})
    );

    // Byte assembly and slot decode
    assign byte_in  = {rx_q[BYTE_W-2:0], sda_i};
    assign last_bit = (cnt_q == SLOT_LAST_DATA);
    assign ack_slot = (cnt_q == SLOT_ACK);

    // Target address fields
    assign type_hit = (byte_in[TYPE_MSB:TYPE_LSB] == DEV_TYPE_CODE);
    assign sel_hit  = (byte_in[SEL_MSB:SEL_LSB] == sel_s);
    assign is_read  = byte_in[DIR_BIT];
    assign hs_hit   = (byte_in[HS_MSB:HS_LSB] == HS_MASTER_CODE);

    // Read continuation and store strobe
    assign rd_next    = (state_q == ST_READ) & ack_slot & ~ack_q;
    assign master_ack = ~sda_i;
    assign mem_we     = (state_q == ST_WDATA) & last_bit & ~guard_s;
    assign blk_ev     = (state_q == ST_WDATA) & last_bit & guard_s;

    // Address arithmetic wraps at 13 bits by width
    assign addr_inc     = addr_q + ADDR_STEP;
    assign ptr_inc      = ptr_q + ADDR_STEP;
    assign word_addr    = {hi_q, byte_in};
    assign rd_byte      = mem_q[addr_q];
    assign rd_next_byte = mem_q[addr_inc];

    // Protocol next state, decided on each rising scl
    always_comb begin
        state_d = state_q;
        cnt_d   = ack_slot ? SLOT_FIRST : cnt_q + SLOT_STEP;
        rx_d    = byte_in;
        tx_d    = tx_q;
        ack_d   = ack_q;
        hi_d    = hi_q;
        addr_d  = addr_q;
        ptr_d   = ptr_q;
        hs_d    = hs_q;
        if ((state_q == ST_READ) && !ack_slot) begin
            tx_d = {tx_q[BYTE_W-2:0], 1'b0};
        end
        if (ack_slot) begin
            ack_d = 1'b0;
            if (rd_next) begin
                addr_d = addr_inc;
                if (master_ack) begin
                    tx_d = rd_next_byte;
                end else begin
                    state_d = ST_IGNORE;
                end
            end
        end else if (last_bit) begin
            unique case (state_q)
                ST_ADDR: begin
                    if (type_hit && sel_hit) begin
                        ack_d   = 1'b1;
                        tx_d    = rd_byte;
                        state_d = is_read ? ST_READ : ST_WHI;
                    end else begin
                        hs_d    = hs_q | hs_hit;
                        state_d = ST_IGNORE;
                    end
                end
                ST_WHI: begin
                    hi_d    = byte_in[HI_ADDR_W-1:0];
                    ack_d   = 1'b1;
                    state_d = ST_WLO;
                end
                ST_WLO: begin
                    ptr_d   = word_addr;
                    addr_d  = word_addr;
                    ack_d   = 1'b1;
                    state_d = ST_WDATA;
                end
                ST_WDATA: begin
                    ack_d  = 1'b1;
                    addr_d = ptr_q;
                    ptr_d  = ptr_inc;
                end
                ST_READ: begin
                    ack_d = 1'b0;
                end
                ST_IGNORE: begin
                    ack_d = 1'b0;
                end
                default: begin
                    state_d = ST_IGNORE;
                end
            endcase
        end
    end

    // Frame state; cleared by start or stop from the core side
    always_ff @(posedge link_scl_i or posedge frame_rst_q) begin
        if (frame_rst_q) begin
            state_q <= ST_ADDR;
            cnt_q   <= SLOT_FIRST;
            rx_q    <= '0;
            tx_q    <= '0;
            ack_q   <= 1'b0;
            hi_q    <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            rx_q    <= rx_d;
            tx_q    <= tx_d;
            ack_q   <= ack_d;
            hi_q    <= hi_d;
        end
    end

    // Address registers survive frames; only core reset clears them
    always_ff @(posedge link_scl_i or posedge link_rst_q) begin
        if (link_rst_q) begin
            addr_q    <= ADDR_RST;
            ptr_q     <= ADDR_RST;
            blk_tog_q <= TOG_RST;
        end else begin
            addr_q    <= addr_d;
            ptr_q     <= ptr_d;
            blk_tog_q <= blk_tog_q ^ blk_ev;
        end
    end

    // High speed lasts across repeated starts, ends at stop
    always_ff @(posedge link_scl_i or posedge idle_q) begin
        if (idle_q) begin
            hs_q <= 1'b0;
        end else begin
            hs_q <= hs_d;
        end
    end

    assign hs_mode_o = hs_q;

    // Storage array, no reset so it maps onto plain flops
    always_ff @(posedge link_scl_i) begin
        if (mem_we) begin
            mem_q[ptr_q] <= byte_in;
        end
    end

    // Pull low for our acknowledge or for a zero data bit
    assign drive_ack  = ack_slot & ack_q;
    assign drive_data = (state_q == ST_READ) & ~ack_slot & ~tx_q[BYTE_W-1];
    assign oe_n_d     = ~(drive_ack | drive_data);

    // Driven level changes only after the falling serial clock edge
    always_ff @(negedge link_scl_i or posedge frame_rst_q) begin
        if (frame_rst_q) begin
            oe_n_q    <= 1'b1;
            drv_lvl_q <= 1'b0;
        end else begin
            oe_n_q    <= oe_n_d;
            drv_lvl_q <= 1'b0;
        end
    end

    // Open drain: level always low, only the enable moves
    assign sda_o      = drv_lvl_q;
    assign sda_oe_n_o = oe_n_q;

endmodule

// ---- verification/nvs_monitor.sv ----
// Concurrent checks on the memory target's ports, core clock domain.
// Assumes sda_i and link_scl_i carry the resolved wire levels.
`timescale 1ns/10ps
module nvs_monitor (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic link_scl_i,
    input wire logic sda_i,
    input wire logic write_guard_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic hs_mode_o,
    input wire logic bus_idle_o,
    input wire logic write_blocked_o
);
    // One domain only, so clock and reset are given once
    default clocking mon_cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    // Open drain: the drive level is never high
    drive_low_a: assert property (
        sda_o == 1'b0)
        else $error("sda drive level went high");
    // Nothing pulls sda before a start is seen
    idle_free_a: assert property (
        bus_idle_o |-> sda_oe_n_o)
        else $error("sda pulled while bus idle");
    // Enable may only move while scl is low
    fall_edge_a: assert property (
        $changed(sda_oe_n_o) |-> !link_scl_i)
        else $error("sda enable moved with scl high");
    // A pulled slot lasts at least three core cycles
    ack_slot_a: assert property (
        $fell(sda_oe_n_o) |-> !sda_oe_n_o [*3])
        else $error("sda pull shorter than a period");
    frame_start_a: assert property (
        $fell(bus_idle_o) |-> link_scl_i && !sda_i)
        else $error("frame opened without start");
    frame_stop_a: assert property (
        $rose(bus_idle_o) |-> link_scl_i && sda_i)
        else $error("frame closed without stop");
    // Fast mode is left only at a stop
    hs_stop_a: assert property (
        $fell(hs_mode_o) |-> link_scl_i && sda_i)
        else $error("fast mode left outside stop");
    guard_cause_a: assert property (
        write_blocked_o |-> write_guard_i && !bus_idle_o)
        else $error("store refused without guard");
    guard_pulse_a: assert property (
        write_blocked_o |=> !write_blocked_o)
        else $error("refusal pulse too long");

    // Main scenarios reached
    cover property ($fell(bus_idle_o));
    cover property (write_blocked_o);
    cover property ($rose(hs_mode_o));
endmodule

bind nvs_i2c_mem nvs_monitor nvs_monitor_inst (
    .core_clk_i      (core_clk_i),
    .rst_i           (rst_i),
    .link_scl_i      (link_scl_i),
    .sda_i           (sda_i),
    .write_guard_i   (write_guard_i),
    .sda_o           (sda_o),
    .sda_oe_n_o      (sda_oe_n_o),
    .hs_mode_o       (hs_mode_o),
    .bus_idle_o      (bus_idle_o),
    .write_blocked_o (write_blocked_o)
);

// ---- verification/nvs_ctl_model.sv ----
// Behavioural two-wire bus controller for the memory target.
// Assumes a pull-up outside; scl stands high between frames.
`timescale 1ns/10ps
module nvs_ctl_model (
    output logic      scl_o,
    output logic      sda_rel_o,
    input  wire logic sda_i
);
    // Bus idles released with scl parked high
    initial begin
        scl_o     = 1'b1;
        sda_rel_o = 1'b1;
    end

    // Start or repeated start; long hold lets the core see it
    task automatic start();
        #20 sda_rel_o = 1'b1;
        #20 scl_o = 1'b1;
        #100 sda_rel_o = 1'b0;
        #200 scl_o = 1'b0;
    endtask

    // Stop: sda rises while scl is high
    task automatic stop();
        #20 sda_rel_o = 1'b0;
        #20 scl_o = 1'b1;
        #200 sda_rel_o = 1'b1;
        #200;
    endtask

    // One 80 ns scl period, data set mid-low, sampled on the rise
    task automatic bit_io(input logic b, output logic s);
        #20 sda_rel_o = b;
        #20 scl_o = 1'b1;
        s = sda_i;
        #40 scl_o = 1'b0;
    endtask

    // Eight bits out, then release for the target's acknowledge
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(v[i], s);
        bit_io(1'b1, ack);
    endtask

    // Eight bits in, then our acknowledge or refusal in slot nine
    task automatic rbyte(input logic nack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(nack, s);
    endtask
endmodule

// ---- verification/test_nvs_i2c_mem.sv ----
// Self-checking bench for the two-wire memory target.
// Assumes the controller model makes scl only inside frames.
`timescale 1ns/10ps
module test_nvs_i2c_mem;
    logic       core_clk_i  = 1'b0;
    logic       rst_i       = 1'b1;
    logic [2:0] sel         = 3'h5;
    logic       guard       = 1'b0;
    wire        scl;
    wire        ctl_rel;
    wire        oe_n;
    wire        hs;
    wire        idle;
    wire        blocked;
    int         blk_cnt     = 0;
    wire        sda_w       = ctl_rel & oe_n;
    int         errors      = 0;
    int         check_count = 0;
    logic [7:0] rd;
    logic       ack;

    always #12.5 core_clk_i = ~core_clk_i;

    // Count refusal pulses; each one lasts a single core cycle
    always @(posedge core_clk_i) begin
        if (blocked === 1'b1) begin
            blk_cnt++;
        end
    end

    // Type code is arbitrary; address bytes below follow from it
    nvs_i2c_mem #(.DEV_TYPE_CODE(4'h6)) nvs_i2c_mem_inst (
        .core_clk_i           (core_clk_i),
        .rst_i                (rst_i),
        .link_scl_i           (scl),
        .sda_i                (sda_w),
        .device_select_pins_i (sel),
        .write_guard_i        (guard),
        .sda_o                (),
        .sda_oe_n_o           (oe_n),
        .hs_mode_o            (hs),
        .bus_idle_o           (idle),
        .write_blocked_o      (blocked)
    );
    nvs_ctl_model nvs_ctl_model_inst (
        .scl_o     (scl),
        .sda_rel_o (ctl_rel),
        .sda_i     (sda_w)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Short aliases for the controller's bus cycles
    task automatic wb(input logic [7:0] v, input logic exp);
        nvs_ctl_model_inst.wbyte(v, ack);
        check(16'(ack), 16'(exp));
    endtask
    task automatic rb(input logic nack, input logic [7:0] exp);
        nvs_ctl_model_inst.rbyte(nack, rd);
        check(16'(rd), 16'(exp));
    endtask
    task automatic addr_phase(input logic [15:0] a);
        nvs_ctl_model_inst.start();
        wb(8'h6A, 1'b0);
        wb(a[15:8], 1'b0);
        wb(a[7:0], 1'b0);
    endtask
    task automatic cur_read(input logic [7:0] exp);
        nvs_ctl_model_inst.start();
        wb(8'h6B, 1'b0);
        rb(1'b1, exp);
        nvs_ctl_model_inst.stop();
    endtask

    // Page write across the top, random, sequential and current reads
    task automatic t_page();
        addr_phase(16'hFFFF);
        wb(8'h11, 1'b0);
        wb(8'h22, 1'b0);
        wb(8'h33, 1'b0);
        nvs_ctl_model_inst.stop();
        addr_phase(16'h1FFF);
        nvs_ctl_model_inst.start();
        wb(8'h6B, 1'b0);
        rb(1'b0, 8'h11);
        rb(1'b1, 8'h22);
        #2 check(16'(oe_n), 16'h0001);
        nvs_ctl_model_inst.stop();
        cur_read(8'h33);
        addr_phase(16'h0005);
        wb(8'h44, 1'b0);
        nvs_ctl_model_inst.stop();
        cur_read(8'h44);
        $display("page and read test done");
    endtask

    // Wrong type code and wrong straps are not acknowledged
    task automatic t_select();
        logic [7:0] bad [2] = '{8'h7A, 8'h68};
        foreach (bad[i]) begin
            nvs_ctl_model_inst.start();
            wb(bad[i], 1'b1);
            nvs_ctl_model_inst.stop();
        end
        @(posedge core_clk_i);
        #2 sel = 3'h3;
        nvs_ctl_model_inst.start();
        wb(8'h66, 1'b0);
        nvs_ctl_model_inst.stop();
        @(posedge core_clk_i);
        #2 sel = 3'h5;
        $display("select test done");
    endtask

    // Guard high: byte acknowledged but memory keeps the old value
    task automatic t_guard();
        @(posedge core_clk_i);
        #2 guard = 1'b1;
        addr_phase(16'h0001);
        wb(8'h55, 1'b0);
        nvs_ctl_model_inst.stop();
        check(16'(blk_cnt), 16'h0001);
        @(posedge core_clk_i);
        #2 guard = 1'b0;
        addr_phase(16'h0001);
        nvs_ctl_model_inst.start();
        wb(8'h6B, 1'b0);
        rb(1'b1, 8'h33);
        nvs_ctl_model_inst.stop();
        $display("guard test done");
    endtask

    // Master code: refused, fast mode held until the stop
    task automatic t_hs();
        nvs_ctl_model_inst.start();
        wb(8'h08, 1'b1);
        check(16'(hs), 16'h0001);
        nvs_ctl_model_inst.stop();
        check(16'(hs), 16'h0000);
        check(16'(idle), 16'h0001);
        $display("fast mode test done");
    endtask

    initial begin
        repeat (4) @(posedge core_clk_i);
        #2 rst_i = 1'b0;
        repeat (4) @(posedge core_clk_i);
        #2 check(16'({idle, oe_n, hs}), 16'h0006);
        t_page();
        t_select();
        t_guard();
        t_hs();
        end_sim();
    end

    // Watchdog well beyond the roughly 35 us the tests need
    initial begin
        #300000;
        errors++;
        end_sim();
    end
endmodule
